// File: hdl/plm_pkg.sv
// Shared constants, types and helpers for the line configuration block.
package plm_pkg;

  // ==========================================================
  // Geometry
  localparam int PLM_LINES = 32;
  localparam int PLM_ADDR_W = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] PLM_PU_CLR_OFF = 8'h00;
  localparam logic [7:0] PLM_PU_SET_OFF = 8'h04;
  localparam logic [7:0] PLM_PU_STA_OFF = 8'h08;
  localparam logic [7:0] PLM_FA_SEL_OFF = 8'h0C;
  localparam logic [7:0] PLM_FB_SEL_OFF = 8'h10;
  localparam logic [7:0] PLM_FN_STA_OFF = 8'h14;
  localparam logic [7:0] PLM_OW_SET_OFF = 8'h18;
  localparam logic [7:0] PLM_OW_CLR_OFF = 8'h1C;
  localparam logic [7:0] PLM_OW_STA_OFF = 8'h20;
  localparam logic [7:0] PLM_LVL_OFF = 8'h24;

  // ==========================================================
  // Reset values of the per-line state
  localparam logic [31:0] PLM_PU_RST = 32'hFFFFFFFF;
  localparam logic [31:0] PLM_FN_RST = 32'h00000000;
  localparam logic [31:0] PLM_OW_RST = 32'h00000000;
  localparam logic [31:0] PLM_LVL_RST = 32'h00000000;

  // ==========================================================
  // Bus slave states
  typedef enum logic [1:0] {
    PLM_ST_IDLE = 2'h1,
    PLM_ST_ACK = 2'h2
  } plm_bus_st_t;

  // Expands byte selects into a bit mask.
  function automatic logic [31:0] plm_lanes(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // True when a strobe targets the given register offset.
  function automatic logic plm_hit(input logic stb, input logic [7:0] adr,
                                   input logic [7:0] off);
    return stb && (adr == off);
  endfunction

endpackage

// File: hdl/plm_reg_if.sv
// Register access carrier between the bus slave and the register core.
`timescale 1ns/1ns
interface plm_reg_if import plm_pkg::*; ();
  logic wr_stb;
  logic rd_stb;
  logic [PLM_ADDR_W-1:0] adr;
  logic [31:0] wdata;
  logic [31:0] wmask;
  logic [31:0] rdata;

  modport bus(output wr_stb, rd_stb, adr, wdata, wmask, input rdata);
  modport core(input wr_stb, rd_stb, adr, wdata, wmask, output rdata);
endinterface

// File: hdl/plm_wb_slave.sv
// Classic Wishbone slave that turns bus cycles into register strobes.
`timescale 1ns/1ns
module plm_wb_slave import plm_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [PLM_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Register side
  plm_reg_if.bus rb
);

  plm_bus_st_t st_reg;
  logic req;

  // =========================================================
  // Request decode
  // A request is taken only in idle, so each cycle gets one strobe.
  assign req = wb_cyc_i && wb_stb_i && (st_reg == PLM_ST_IDLE);
  assign rb.wr_stb = req && wb_we_i;
  assign rb.rd_stb = req && !wb_we_i;
  assign rb.adr = {wb_adr_i[PLM_ADDR_W-1:2], 2'h0};
  assign rb.wdata = wb_dat_i;
  assign rb.wmask = plm_lanes(wb_sel_i);

  // Walks idle, then one acknowledge cycle, then back to idle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= PLM_ST_IDLE;
    end else begin
      case (st_reg)
        PLM_ST_IDLE: begin
          if (req) begin
            st_reg <= PLM_ST_ACK;
          end
        end
        PLM_ST_ACK: begin
          st_reg <= PLM_ST_IDLE;
        end
        default: begin
          st_reg <= PLM_ST_IDLE;
        end
      endcase
    end
  end

  // Acknowledge pulses once, in the cycle after the request is taken.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data is captured together with the acknowledge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h00000000;
    end else if (req) begin
      wb_dat_o <= wb_we_i ? 32'h00000000 : rb.rdata;
    end
  end

endmodule

// File: hdl/plm_setclr_bank.sv
// Bank of per-line state bits driven by set and clear masks.
`timescale 1ns/1ns
module plm_setclr_bank #(
  parameter int W = 32,
  parameter logic [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Masks, one-cycle
  input wire logic [W-1:0] set_mask,
  input wire logic [W-1:0] clr_mask,
  // State
  output logic [W-1:0] state_reg
);

  // Ones set or clear their line; zeros keep it.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RST;
    end else begin
      state_reg <= (state_reg | set_mask) & ~clr_mask;
    end
  end

endmodule

// File: hdl/plm_top.sv
// Per-line pull-up, function select and output write mask for the I/O lines.
`timescale 1ns/1ns

module plm_top import plm_pkg::*; #(
  parameter int NLINES = PLM_LINES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [PLM_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pad controls, one bit per line
  output logic [NLINES-1:0] line_pullup_en,
  output logic [NLINES-1:0] line_func_b,
  output logic [NLINES-1:0] line_out_level
);

  // =========================================================
  // Bus slave
  plm_reg_if rif();

  plm_wb_slave u_bus (
    .core_clk(core_clk),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rb(rif.bus)
  );

  // =========================================================
  // Write masks
  logic [NLINES-1:0] wd;
  logic [NLINES-1:0] lane_m;
  logic [NLINES-1:0] pu_set_m;
  logic [NLINES-1:0] pu_clr_m;
  logic [NLINES-1:0] fa_m;
  logic [NLINES-1:0] fb_m;
  logic [NLINES-1:0] ow_set_m;
  logic [NLINES-1:0] ow_clr_m;
  logic [NLINES-1:0] pu_en_reg;
  logic [NLINES-1:0] func_b_reg;
  logic [NLINES-1:0] ow_en_reg;
  logic [NLINES-1:0] lvl_reg;
  logic lvl_wr;

  // Bit n of the bus word drives line n, gated by byte lanes.
  assign lane_m = rif.wmask[NLINES-1:0];
  assign wd = rif.wdata[NLINES-1:0] & lane_m;

  // Each write-only register turns its ones into a one-cycle mask.
  assign pu_clr_m = plm_hit(rif.wr_stb, rif.adr, PLM_PU_CLR_OFF) ? wd : '0;
  assign pu_set_m = plm_hit(rif.wr_stb, rif.adr, PLM_PU_SET_OFF) ? wd : '0;
  assign fa_m = plm_hit(rif.wr_stb, rif.adr, PLM_FA_SEL_OFF) ? wd : '0;
  assign fb_m = plm_hit(rif.wr_stb, rif.adr, PLM_FB_SEL_OFF) ? wd : '0;
  assign ow_set_m = plm_hit(rif.wr_stb, rif.adr, PLM_OW_SET_OFF) ? wd : '0;
  assign ow_clr_m = plm_hit(rif.wr_stb, rif.adr, PLM_OW_CLR_OFF) ? wd : '0;
  assign lvl_wr = plm_hit(rif.wr_stb, rif.adr, PLM_LVL_OFF);

  // =========================================================
  // Per-line state, one shared bit per setting
  // Pull-up enable: set register raises, clear register drops.
  plm_setclr_bank #(.W(NLINES), .RST(PLM_PU_RST[NLINES-1:0])) u_pu (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_mask(pu_set_m),
    .clr_mask(pu_clr_m),
    .state_reg(pu_en_reg)
  );

  // Function select: one means B, so B raises and A drops.
  plm_setclr_bank #(.W(NLINES), .RST(PLM_FN_RST[NLINES-1:0])) u_fn (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_mask(fb_m),
    .clr_mask(fa_m),
    .state_reg(func_b_reg)
  );

  // Output write mask: one lets level writes reach the line.
  plm_setclr_bank #(.W(NLINES), .RST(PLM_OW_RST[NLINES-1:0])) u_ow (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_mask(ow_set_m),
    .clr_mask(ow_clr_m),
    .state_reg(ow_en_reg)
  );

  // =========================================================
  // Output level register
  // Only lines whose write mask is set take the new level.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lvl_reg <= PLM_LVL_RST[NLINES-1:0];
    end else if (lvl_wr) begin
      lvl_reg <= (lvl_reg & ~(ow_en_reg & lane_m)) | (wd & ow_en_reg);
    end
  end

  // =========================================================
  // Read mux
  // Status registers show the shared bits, pull-up inverted; write-only ones read zero.
  always_comb begin
    case (rif.adr)
      PLM_PU_STA_OFF: begin
        rif.rdata = 32'(~pu_en_reg);
      end
      PLM_FN_STA_OFF: begin
        rif.rdata = 32'(func_b_reg);
      end
      PLM_OW_STA_OFF: begin
        rif.rdata = 32'(ow_en_reg);
      end
      PLM_LVL_OFF: begin
        rif.rdata = 32'(lvl_reg);
      end
      default: begin
        rif.rdata = 32'h00000000;
      end
    endcase
  end

  // Pad controls come straight from the state flops.
  assign line_pullup_en = pu_en_reg;
  assign line_func_b = func_b_reg;
  assign line_out_level = lvl_reg;

  // =========================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  logic rd_pu;
  logic rd_fn;
  logic rd_ow;
  logic rd_wo;
  logic rd_lvl;

  // Read requests by target, for checks on the returned word.
  assign rd_pu = plm_hit(rif.rd_stb, rif.adr, PLM_PU_STA_OFF);
  assign rd_fn = plm_hit(rif.rd_stb, rif.adr, PLM_FN_STA_OFF);
  assign rd_ow = plm_hit(rif.rd_stb, rif.adr, PLM_OW_STA_OFF);
  assign rd_lvl = plm_hit(rif.rd_stb, rif.adr, PLM_LVL_OFF);
  assign rd_wo = rif.rd_stb && !rd_pu && !rd_fn && !rd_ow
                 && (rif.adr != PLM_LVL_OFF);

  // Set and clear writes act on their ones and on nothing else.
  pu_clear_a: assert property (
    plm_hit(rif.wr_stb, rif.adr, PLM_PU_CLR_OFF) |=>
      ((line_pullup_en & $past(wd)) == '0) &&
      (((line_pullup_en ^ $past(line_pullup_en)) & ~$past(wd)) == '0))
    else $error("pull-up clear did not act per bit");

  pu_set_a: assert property (
    plm_hit(rif.wr_stb, rif.adr, PLM_PU_SET_OFF) |=>
      ((~line_pullup_en & $past(wd)) == '0) &&
      (((line_pullup_en ^ $past(line_pullup_en)) & ~$past(wd)) == '0))
    else $error("pull-up set did not act per bit");

  // Pull-up status returns the inverted enable with the acknowledge.
  pu_status_a: assert property (
    rd_pu |=> wb_ack_o && (wb_dat_o[NLINES-1:0] == ~$past(line_pullup_en)))
    else $error("pull-up status not inverted enable");

  // Function A select clears the shared bit, B select sets it.
  func_a_a: assert property (
    plm_hit(rif.wr_stb, rif.adr, PLM_FA_SEL_OFF) |=>
      ((line_func_b & $past(wd)) == '0) &&
      (((line_func_b ^ $past(line_func_b)) & ~$past(wd)) == '0))
    else $error("function A select did not act per bit");

  func_b_a: assert property (
    plm_hit(rif.wr_stb, rif.adr, PLM_FB_SEL_OFF) |=>
      ((~line_func_b & $past(wd)) == '0) &&
      (((line_func_b ^ $past(line_func_b)) & ~$past(wd)) == '0))
    else $error("function B select did not act per bit");

  // Function status returns the shared bit, one meaning B.
  func_status_a: assert property (
    rd_fn |=> wb_ack_o && (wb_dat_o[NLINES-1:0] == $past(line_func_b)))
    else $error("function status differs from selection");

  // Write mask set and clear act on their ones only.
  ow_set_a: assert property (
    plm_hit(rif.wr_stb, rif.adr, PLM_OW_SET_OFF) |=>
      ((~ow_en_reg & $past(wd)) == '0) &&
      (((ow_en_reg ^ $past(ow_en_reg)) & ~$past(wd)) == '0))
    else $error("write mask set did not act per bit");

  ow_clear_a: assert property (
    plm_hit(rif.wr_stb, rif.adr, PLM_OW_CLR_OFF) |=>
      ((ow_en_reg & $past(wd)) == '0) &&
      (((ow_en_reg ^ $past(ow_en_reg)) & ~$past(wd)) == '0))
    else $error("write mask clear did not act per bit");

  // Write mask status returns the mask itself.
  ow_status_a: assert property (
    rd_ow |=> wb_ack_o && (wb_dat_o[NLINES-1:0] == $past(ow_en_reg)))
    else $error("write mask status differs from mask");

  // A level write reaches only masked-in lines of selected lanes.
  level_mask_a: assert property (
    lvl_wr |=>
      (((line_out_level ^ $past(line_out_level)) &
        ~($past(ow_en_reg) & $past(lane_m))) == '0) &&
      (((line_out_level ^ $past(wd)) & $past(ow_en_reg) & $past(lane_m)) == '0))
    else $error("level write crossed the write mask");

  // Write-only and unmapped reads return a zero word.
  wo_read_a: assert property (
    rd_wo |=> wb_ack_o && (wb_dat_o == 32'h00000000))
    else $error("write-only or unmapped read not zero");

  // Level register reads back the stored levels.
  lvl_status_a: assert property (
    rd_lvl |=> wb_ack_o && (wb_dat_o[NLINES-1:0] == $past(line_out_level)))
    else $error("level readback differs from level");

  // Levels move only on a level write.
  level_hold_a: assert property (
    !lvl_wr |=> $stable(line_out_level))
    else $error("level changed without a level write");

  // Writes return a zero data word with their acknowledge.
  wr_data_zero_a: assert property (
    rif.wr_stb |=> wb_ack_o && (wb_dat_o == 32'h00000000))
    else $error("write acknowledge carried data");

  // A standing request is answered by one acknowledge cycle.
  ack_pulse_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("acknowledge not a single cycle pulse");

  // Every acknowledge answers a request taken one cycle before.
  ack_source_a: assert property (
    wb_ack_o |-> $past(rif.wr_stb || rif.rd_stb))
    else $error("acknowledge without a request");

  // No request is taken while the acknowledge stands.
  ack_busy_a: assert property (
    wb_ack_o |-> !rif.wr_stb && !rif.rd_stb)
    else $error("request taken during acknowledge");

  // Read data holds until the next request is taken.
  dat_hold_a: assert property (
    !(rif.wr_stb || rif.rd_stb) |=> $stable(wb_dat_o))
    else $error("read data moved between requests");

  // =========================================================
  // Per-line checks
  // A line whose bit is zero in both masks keeps its setting.
  for (genvar n = 0; n < NLINES; n++) begin : g_line
    line_pu_a: assert property (
      (!pu_set_m[n] && !pu_clr_m[n]) |=> $stable(line_pullup_en[n]))
      else $error("pull-up of a line moved without its bit");
    line_fn_a: assert property (
      (!fa_m[n] && !fb_m[n]) |=> $stable(line_func_b[n]))
      else $error("function of a line moved without its bit");
    line_ow_a: assert property (
      (!ow_set_m[n] && !ow_clr_m[n]) |=> $stable(ow_en_reg[n]))
      else $error("write mask of a line moved without its bit");
  end

  // =========================================================
  // Cover points
  // Bench requests are three cycles apart at the closest, so the gap is three.
  pu_write_c: cover property (
    plm_hit(rif.wr_stb, rif.adr, PLM_PU_CLR_OFF) ##3
    plm_hit(rif.wr_stb, rif.adr, PLM_PU_SET_OFF));

  func_b_c: cover property (
    plm_hit(rif.wr_stb, rif.adr, PLM_FB_SEL_OFF) ##[2:8] rd_fn);

  masked_level_c: cover property (
    lvl_wr && (ow_en_reg != '0) && (ow_en_reg != '1));

  level_blocked_c: cover property (
    lvl_wr && (ow_en_reg == '0));

  unmapped_c: cover property (rd_wo && (rif.adr > PLM_LVL_OFF));

endmodule

// File: dv/test_plm_top.sv
// Self-checking bench for the line configuration block.
`timescale 1ns/1ns
module test_plm_top import plm_pkg::*; ;
  // ==========================================================
  // Signals and expected line state
  logic core_clk;
  logic nrst;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [PLM_ADDR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] line_pullup_en;
  logic [31:0] line_func_b;
  logic [31:0] line_out_level;
  logic [31:0] rd;
  logic [31:0] pu;
  logic [31:0] fb;
  logic [31:0] ow;
  logic [31:0] lvl;
  int failures;
  int samples_checked;
  int cycles;

  // ==========================================================
  // Device under test
  plm_top #(.NLINES(32)) i_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .line_pullup_en(line_pullup_en), .line_func_b(line_func_b),
    .line_out_level(line_out_level));

  // Clock of 50 ns period.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Cuts a hung run short; the whole run needs about a hundred cycles.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      $display("mismatch timeout expected done seen hang");
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                     input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wdat;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    rd = wb_dat_o;
    if (n >= 20) begin
      failures++;
      $display("mismatch ack expected 1 seen none");
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h00000000, 4'hF);
    check(what, rd, exp);
  endtask

  // Compares all three line outputs with the expected state.
  task automatic lines(input string what);
    check({what, " pullup"}, line_pullup_en, pu);
    check({what, " func"}, line_func_b, fb);
    check({what, " level"}, line_out_level, lvl);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    lines("reset");
    rchk("pullup state", PLM_PU_STA_OFF, ~PLM_PU_RST);
    rchk("func state", PLM_FN_STA_OFF, PLM_FN_RST);
    rchk("mask state", PLM_OW_STA_OFF, PLM_OW_RST);
    $display("test reset done");
  endtask

  task automatic t_pullup();
    bus(1'b1, PLM_PU_CLR_OFF, 32'hA5A50F01, 4'hF);
    pu = pu & ~32'hA5A50F01;
    check("pullup clear", line_pullup_en, pu);
    rchk("pullup state", PLM_PU_STA_OFF, ~pu);
    bus(1'b1, PLM_PU_SET_OFF, 32'h80000101, 4'hF);
    pu = pu | 32'h80000101;
    check("pullup set", line_pullup_en, pu);
    bus(1'b1, PLM_PU_CLR_OFF, 32'hFFFFFFFF, 4'h2);
    pu = pu & ~32'h0000FF00;
    check("pullup lane", line_pullup_en, pu);
    bus(1'b1, PLM_PU_SET_OFF, 32'h00000000, 4'hF);
    check("pullup zero", line_pullup_en, pu);
    rchk("pullup state", PLM_PU_STA_OFF, ~pu);
    $display("test pullup done");
  endtask

  task automatic t_func();
    bus(1'b1, PLM_FB_SEL_OFF, 32'h8000FF01, 4'hF);
    fb = 32'h8000FF01;
    check("func b", line_func_b, fb);
    bus(1'b1, PLM_FA_SEL_OFF, 32'h80000100, 4'hF);
    fb = 32'h0000FE01;
    check("func a", line_func_b, fb);
    rchk("func state", PLM_FN_STA_OFF, fb);
    $display("test func done");
  endtask

  task automatic t_mask();
    bus(1'b1, PLM_LVL_OFF, 32'hFFFFFFFF, 4'hF);
    check("level blocked", line_out_level, lvl);
    bus(1'b1, PLM_OW_SET_OFF, 32'h0000FFFF, 4'hF);
    ow = 32'h0000FFFF;
    rchk("mask state", PLM_OW_STA_OFF, ow);
    bus(1'b1, PLM_LVL_OFF, 32'h12345678, 4'hF);
    lvl = 32'h00005678;
    check("level enabled", line_out_level, lvl);
    bus(1'b1, PLM_OW_CLR_OFF, 32'h000000FF, 4'hF);
    ow = 32'h0000FF00;
    bus(1'b1, PLM_LVL_OFF, 32'h00000000, 4'hF);
    lvl = 32'h00000078;
    check("level disabled", line_out_level, lvl);
    rchk("level state", PLM_LVL_OFF, lvl);
    rchk("mask state", PLM_OW_STA_OFF, ow);
    $display("test mask done");
  endtask

  // A reset in mid-run returns every setting to its reset value.
  task automatic t_midreset();
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    pu = PLM_PU_RST;
    fb = PLM_FN_RST;
    ow = PLM_OW_RST;
    lvl = PLM_LVL_RST;
    lines("mid reset");
    @(posedge core_clk);
    nrst <= 1'b1;
    rchk("mask state", PLM_OW_STA_OFF, ow);
    $display("test midreset done");
  endtask

  task automatic t_refuse();
    logic [7:0] wo [6];
    wo = '{PLM_PU_CLR_OFF, PLM_PU_SET_OFF, PLM_FA_SEL_OFF, PLM_FB_SEL_OFF,
           PLM_OW_SET_OFF, PLM_OW_CLR_OFF};
    foreach (wo[i]) begin
      rchk("write-only read", wo[i], 32'h00000000);
    end
    rchk("unmapped read", 8'hFC, 32'h00000000);
    bus(1'b1, PLM_PU_STA_OFF, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, PLM_FN_STA_OFF, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, 8'h40, 32'hFFFFFFFF, 4'hF);
    lines("refused write");
    $display("test refuse done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    failures = 0;
    samples_checked = 0;
    pu = PLM_PU_RST;
    fb = PLM_FN_RST;
    ow = PLM_OW_RST;
    lvl = PLM_LVL_RST;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_pullup();
    t_func();
    t_mask();
    t_midreset();
    t_refuse();
    give_verdict();
  end
endmodule
